// File: hw/dhp_defines.svh
`ifndef DHP_DEFINES_SVH
`define DHP_DEFINES_SVH
// strap encoding {iface_strap_a, iface_strap_b}
`define DHP_MODE_SERIAL   2'h0
`define DHP_MODE_PAR_SEP  2'h1
`define DHP_MODE_I2C      2'h2
`define DHP_MODE_PAR_EN   2'h3
// reset state of the driver
`define DHP_CONTRAST_RST  8'h80
`define DHP_COL_RST       8'h00
`define DHP_START_RST     6'h00
// upper six bits of the i2c slave address
`define DHP_I2C_ADDR_HI   6'h1e
// bus bit positions
`define DHP_SCLK_BIT      0
`define DHP_SERIAL_DATA_IN_BIT      1
`define DHP_SDA_OUT_BIT   2
`define DHP_BITS_PER_BYTE 4'h8
// host step timing
`define DHP_CLK_NS        20
`define DHP_STEP_NS       200
`define DHP_I2C_STEP_NS   1300
`define DHP_STEP_CYC      ((`DHP_STEP_NS + `DHP_CLK_NS - 1) / `DHP_CLK_NS)
`define DHP_I2C_STEP_CYC  ((`DHP_I2C_STEP_NS + `DHP_CLK_NS - 1) / `DHP_CLK_NS)
`define DHP_PAR_LAST      6'h04
`define DHP_SER_LAST      6'h11
`define DHP_I2C_LAST      6'h39
`endif

// File: hw/dhp_pkg.sv
package dhp_pkg;
  typedef enum logic [1:0] {
    DHP_I2C_IDLE = 2'h0,
    DHP_I2C_ADDR = 2'h1,
    DHP_I2C_CTRL = 2'h3,
    DHP_I2C_DATA = 2'h2
  } dhp_i2c_st_t;

  typedef struct packed {
    logic       strap_a;
    logic       strap_b;
    logic       rst_n;
    logic       cs_n;
    logic       dc;
    logic       rw;
    logic       en;
    logic [7:0] bus;
  } dhp_pins_t;
endpackage

// File: hw/dhp_if.sv
`include "dhp_defines.svh"
interface dhp_if;
  logic       iface_strap_a;
  logic       iface_strap_b;
  logic       chip_reset_n;
  logic       cs_n;
  logic       dc;
  logic       rw_wr_n;
  logic       en_rd_n;
  logic [7:0] host_bus_o;
  logic [7:0] host_bus_oe_n;
  logic [7:0] dev_bus_o;
  logic [7:0] dev_bus_oe_n;
  logic [7:0] raw_level;
  logic [7:0] host_data_bus;

  // pulled-up wire: a released bit reads high, any driven low wins
  assign raw_level = (host_bus_oe_n | host_bus_o) & (dev_bus_oe_n | dev_bus_o);
  always_comb begin
    host_data_bus = raw_level;
    if ({iface_strap_a, iface_strap_b} == `DHP_MODE_I2C) begin
      host_data_bus[`DHP_SERIAL_DATA_IN_BIT]    = raw_level[1] & raw_level[2];
      host_data_bus[`DHP_SDA_OUT_BIT] = raw_level[1] & raw_level[2];
    end
  end

  modport host (output iface_strap_a, iface_strap_b, chip_reset_n, cs_n, dc, rw_wr_n,
                output en_rd_n, host_bus_o, host_bus_oe_n, input host_data_bus);
  modport device (input iface_strap_a, iface_strap_b, chip_reset_n, cs_n, dc, rw_wr_n,
                  input en_rd_n, host_data_bus, output dev_bus_o, dev_bus_oe_n);
endinterface

// File: hw/dhp_device.sv
// Summary of operation
// - traffic accepted only with select low, except in i2c mode
// - parallel byte: dc high data, low command
// - serial byte: dc high data, low command
// - i2c mode: dc is address low bit
// - enable mode: rw high read, low write
// - enable mode: access starts on enable high
// - strobe mode: write taken as write returns high
// - strobe mode: read low, device drives bus
// - serial mode: host holds both strobes low
// - serial mode: bit1 data, bit0 clock
// - i2c: bit2 sda out, bit1 in, bit0 clock
// - reset low initialises the whole controller
// - eight bit bidirectional parallel data path
// - two straps pick protocol, held fixed
// - reset state: off, zeros, contrast 80h
`include "dhp_defines.svh"
module dhp_device
  import dhp_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  dhp_if.device           pins,
  input  wire logic [7:0] rd_data_i,
  output logic            wr_stb_o,
  output logic [7:0]      wr_data_o,
  output logic            wr_is_data_o,
  output logic            rd_stb_o,
  output logic            init_active_o,
  output logic            display_on_o,
  output logic [5:0]      start_line_o,
  output logic [7:0]      col_addr_o,
  output logic            seg_remap_o,
  output logic            com_scan_rev_o,
  output logic [7:0]      contrast_o
);
  dhp_pins_t   s1_reg;
  dhp_pins_t   s2_reg;
  dhp_pins_t   q_reg;
  dhp_pins_t   raw;
  logic [1:0]  mode_reg,    mode_next;
  logic [7:0]  sh_reg,      sh_next;
  logic [3:0]  cnt_reg,     cnt_next;
  dhp_i2c_st_t st_reg,      st_next;
  logic        dcl_reg,     dcl_next;
  logic        ok_reg,      ok_next;
  logic        ack_reg,     ack_next;
  logic        wr_stb_reg,  wr_stb_next;
  logic [7:0]  wr_data_reg, wr_data_next;
  logic        wr_dc_reg,   wr_dc_next;
  logic        rd_stb_reg,  rd_stb_next;
  logic [7:0]  rd_data_reg, rd_data_next;
  logic [7:0]  oe_n_reg,    oe_n_next;
  logic [7:0]  col_reg,     col_next;
  logic        init_reg,    init_next;
  logic        reading;
  logic [7:0]  byte_in;

  assign raw = '{pins.iface_strap_a, pins.iface_strap_b, pins.chip_reset_n, pins.cs_n,
                 pins.dc, pins.rw_wr_n, pins.en_rd_n, pins.host_data_bus};

  // every pin is asynchronous to clk_sys_i; only s2 and later are looked at
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      q_reg  <= '0;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      q_reg  <= s2_reg;
    end
  end

  always_comb begin
    mode_next    = mode_reg;
    sh_next      = sh_reg;
    cnt_next     = cnt_reg;
    st_next      = st_reg;
    dcl_next     = dcl_reg;
    ok_next      = ok_reg;
    ack_next     = ack_reg;
    wr_stb_next  = 1'b0;
    wr_data_next = wr_data_reg;
    wr_dc_next   = wr_dc_reg;
    rd_stb_next  = 1'b0;
    rd_data_next = rd_data_reg;
    col_next     = col_reg;
    init_next    = 1'b0;
    reading      = 1'b0;
    byte_in      = {sh_reg[6:0], s2_reg.bus[`DHP_SERIAL_DATA_IN_BIT]};
    if (!s2_reg.rst_n) begin
      // init also re-latches the straps, which are frozen once it ends
      init_next = 1'b1;
      mode_next = {s2_reg.strap_a, s2_reg.strap_b};
      sh_next   = 8'h00;
      cnt_next  = 4'h0;
      st_next   = DHP_I2C_IDLE;
      dcl_next  = 1'b0;
      ok_next   = 1'b0;
      ack_next  = 1'b0;
      col_next  = `DHP_COL_RST;
    end else begin
      unique case (mode_reg)
        `DHP_MODE_PAR_EN: begin
          reading = !s2_reg.cs_n && s2_reg.en && s2_reg.rw;
          if (!s2_reg.cs_n && s2_reg.en && !q_reg.en && s2_reg.rw) begin
            rd_stb_next  = 1'b1;
            rd_data_next = rd_data_i;
          end
          // write data is taken as the strobe falls, when it is settled
          if (!s2_reg.cs_n && !s2_reg.en && q_reg.en && !s2_reg.rw) begin
            wr_stb_next  = 1'b1;
            wr_data_next = s2_reg.bus;
            wr_dc_next   = s2_reg.dc;
          end
        end
        `DHP_MODE_PAR_SEP: begin
          reading = !s2_reg.cs_n && !s2_reg.en;
          if (!s2_reg.cs_n && !s2_reg.en && q_reg.en) begin
            rd_stb_next  = 1'b1;
            rd_data_next = rd_data_i;
          end
          if (!s2_reg.cs_n && s2_reg.rw && !q_reg.rw) begin
            wr_stb_next  = 1'b1;
            wr_data_next = s2_reg.bus;
            wr_dc_next   = s2_reg.dc;
          end
        end
        `DHP_MODE_SERIAL: begin
          // strobes are held low by the host and are not looked at here
          if (s2_reg.cs_n) begin
            cnt_next = 4'h0;
          end else if (s2_reg.bus[`DHP_SCLK_BIT] && !q_reg.bus[`DHP_SCLK_BIT]) begin
            sh_next  = byte_in;
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == `DHP_BITS_PER_BYTE - 4'h1) begin
              cnt_next     = 4'h0;
              wr_stb_next  = 1'b1;
              wr_data_next = byte_in;
              wr_dc_next   = s2_reg.dc;
            end
          end
        end
        default: begin
          // i2c: sda in on bit1, scl on bit0, no select gating
          if (s2_reg.bus[`DHP_SCLK_BIT] && q_reg.bus[1] && !s2_reg.bus[1]) begin
            st_next  = DHP_I2C_ADDR;
            cnt_next = 4'h0;
            ok_next  = 1'b0;
          end else if (s2_reg.bus[`DHP_SCLK_BIT] && !q_reg.bus[1] && s2_reg.bus[1]) begin
            st_next = DHP_I2C_IDLE;
            ok_next = 1'b0;
          end else if (s2_reg.bus[0] && !q_reg.bus[0] && st_reg != DHP_I2C_IDLE) begin
            if (cnt_reg == `DHP_BITS_PER_BYTE) begin
              cnt_next = 4'h0;
            end else begin
              sh_next  = byte_in;
              cnt_next = cnt_reg + 4'h1;
              if (cnt_reg == `DHP_BITS_PER_BYTE - 4'h1) begin
                ok_next = 1'b1;
                unique case (st_reg)
                  DHP_I2C_ADDR: begin
                    // only write transfers are answered
                    ok_next = byte_in == {`DHP_I2C_ADDR_HI, s2_reg.dc, 1'b0};
                    st_next = ok_next ? DHP_I2C_CTRL : DHP_I2C_IDLE;
                  end
                  DHP_I2C_CTRL: begin
                    dcl_next = byte_in[6];
                    st_next  = DHP_I2C_DATA;
                  end
                  DHP_I2C_DATA: begin
                    wr_stb_next  = 1'b1;
                    wr_data_next = byte_in;
                    wr_dc_next   = dcl_reg;
                  end
                  DHP_I2C_IDLE: ok_next = 1'b0;
                endcase
              end
            end
          end
          if (!s2_reg.bus[0] && q_reg.bus[0]) begin
            ack_next = (cnt_reg == `DHP_BITS_PER_BYTE) && ok_reg;
          end
        end
      endcase
      if (wr_stb_next && wr_dc_next) begin
        col_next = col_reg + 8'h01;
      end
    end
    oe_n_next = reading ? 8'h00 : 8'hff;
    oe_n_next[`DHP_SDA_OUT_BIT] = !(ack_next || reading);
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mode_reg    <= `DHP_MODE_SERIAL;
      sh_reg      <= 8'h00;
      cnt_reg     <= 4'h0;
      st_reg      <= DHP_I2C_IDLE;
      dcl_reg     <= 1'b0;
      ok_reg      <= 1'b0;
      ack_reg     <= 1'b0;
      wr_stb_reg  <= 1'b0;
      wr_data_reg <= 8'h00;
      wr_dc_reg   <= 1'b0;
      rd_stb_reg  <= 1'b0;
      rd_data_reg <= 8'h00;
      oe_n_reg    <= 8'hff;
      col_reg     <= `DHP_COL_RST;
      init_reg    <= 1'b1;
    end else begin
      mode_reg    <= mode_next;
      sh_reg      <= sh_next;
      cnt_reg     <= cnt_next;
      st_reg      <= st_next;
      dcl_reg     <= dcl_next;
      ok_reg      <= ok_next;
      ack_reg     <= ack_next;
      wr_stb_reg  <= wr_stb_next;
      wr_data_reg <= wr_data_next;
      wr_dc_reg   <= wr_dc_next;
      rd_stb_reg  <= rd_stb_next;
      rd_data_reg <= rd_data_next;
      oe_n_reg    <= oe_n_next;
      col_reg     <= col_next;
      init_reg    <= init_next;
    end
  end

  // ack drives a zero on the sda output bit; reads drive the captured byte
  assign pins.dev_bus_o    = ack_reg ? 8'h00 : rd_data_reg;
  assign pins.dev_bus_oe_n = oe_n_reg;
  assign wr_stb_o       = wr_stb_reg;
  assign wr_data_o      = wr_data_reg;
  assign wr_is_data_o   = wr_dc_reg;
  assign rd_stb_o       = rd_stb_reg;
  assign init_active_o  = init_reg;
  // no command decoder here: all but col_addr_o hold their reset state; col_addr_o counts data writes
  assign display_on_o   = 1'b0;
  assign start_line_o   = `DHP_START_RST;
  assign col_addr_o     = col_reg;
  assign seg_remap_o    = 1'b0;
  assign com_scan_rev_o = 1'b0;
  assign contrast_o     = `DHP_CONTRAST_RST;
endmodule // dhp_device

// File: hw/dhp_host.sv
`include "dhp_defines.svh"
module dhp_host
  import dhp_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  dhp_if.host             pins,
  input  wire logic [1:0] mode_i,
  input  wire logic       chip_reset_req_i,
  input  wire logic       slave_addr_low_bit_i,
  input  wire logic       req_i,
  input  wire logic       req_read_i,
  input  wire logic       req_dc_i,
  input  wire logic [7:0] req_data_i,
  output logic            ready_o,
  output logic            rd_valid_o,
  output logic [7:0]      rd_data_o
);
  logic [7:0]  s1_reg;
  logic [7:0]  s2_reg;
  logic        act_reg,  act_next;
  logic [5:0]  step_reg, step_next;
  logic [6:0]  div_reg,  div_next;
  logic        rd_reg,   rd_next;
  logic        dc_reg,   dc_next;
  logic [7:0]  dat_reg,  dat_next;
  logic        rv_reg,   rv_next;
  logic [7:0]  rdd_reg,  rdd_next;
  logic [14:0] pin_reg,  pin_next;
  logic [7:0]  oe_reg,   oe_next;
  logic [1:0]  mode_reg;
  logic        rstp_reg;
  logic        tick;
  logic        strobe;
  logic [5:0]  last;
  logic [4:0]  k;
  logic [26:0] frame;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s1_reg <= 8'h00;
      s2_reg <= 8'h00;
    end else begin
      s1_reg <= pins.host_data_bus;
      s2_reg <= s1_reg;
    end
  end

  always_comb begin
    act_next  = act_reg;
    step_next = step_reg;
    div_next  = div_reg;
    rd_next   = rd_reg;
    dc_next   = dc_reg;
    dat_next  = dat_reg;
    rv_next   = 1'b0;
    rdd_next  = rdd_reg;
    last      = (mode_reg == `DHP_MODE_I2C) ? `DHP_I2C_LAST :
                (mode_reg == `DHP_MODE_SERIAL) ? `DHP_SER_LAST : `DHP_PAR_LAST;
    tick      = act_reg && (div_reg == ((mode_reg == `DHP_MODE_I2C) ?
                7'(`DHP_I2C_STEP_CYC - 1) : 7'(`DHP_STEP_CYC - 1)));
    if (!act_reg && req_i) begin
      act_next  = 1'b1;
      step_next = 6'h00;
      div_next  = 7'h00;
      // reads only exist on the parallel protocols
      rd_next   = req_read_i && mode_reg[0];
      dc_next   = req_dc_i;
      dat_next  = req_data_i;
    end else if (act_reg) begin
      div_next = div_reg + 7'h01;
      if (tick) begin
        div_next  = 7'h00;
        step_next = step_reg + 6'h01;
        if (rd_reg && step_reg == 6'h02) begin
          rv_next  = 1'b1;
          rdd_next = s2_reg;
        end
        if (step_reg == last) begin
          act_next = 1'b0;
        end
      end
    end
    // pin_next = {cs_n, dc, rw_wr_n, en_rd_n, reset_n, bus_o[7:0], spare[1:0]}
    strobe = act_reg && (step_reg == 6'h01 || step_reg == 6'h02);
    k      = 5'((step_reg - 6'h01) >> 1);
    frame  = {`DHP_I2C_ADDR_HI, slave_addr_low_bit_i, 1'b0, 1'b1,
              1'b0, dc_reg, 6'h00, 1'b1, dat_reg, 1'b1};
    pin_next = {1'b1, dc_reg, 1'b0, 1'b0, !chip_reset_req_i, 8'hff, 2'h0};
    oe_next  = 8'hff;
    unique case (mode_reg)
      `DHP_MODE_PAR_EN: begin
        pin_next[14]    = !(act_reg && step_reg <= 6'h03);
        pin_next[12]    = rd_reg;
        pin_next[11]    = strobe;
        pin_next[9:2]   = dat_reg;
        oe_next         = (act_reg && !rd_reg) ? 8'h00 : 8'hff;
      end
      `DHP_MODE_PAR_SEP: begin
        pin_next[14]    = !(act_reg && step_reg <= 6'h03);
        pin_next[12]    = !(strobe && !rd_reg);
        pin_next[11]    = !(strobe && rd_reg);
        pin_next[9:2]   = dat_reg;
        oe_next         = (act_reg && !rd_reg) ? 8'h00 : 8'hff;
      end
      `DHP_MODE_SERIAL: begin
        // strobes stay low in this mode
        pin_next[14]    = !(act_reg && step_reg < `DHP_SER_LAST);
        pin_next[2]     = act_reg && step_reg != 6'h00 && !step_reg[0];
        pin_next[3]     = dat_reg[3'(3'h7 - 3'(k))];
        oe_next         = 8'hfc;
      end
      default: begin
        pin_next[13]    = slave_addr_low_bit_i;
        pin_next[2]     = 1'b1;
        pin_next[3]     = 1'b1;
        if (act_reg) begin
          if (step_reg == 6'h00) begin
            pin_next[3] = 1'b0;
          end else if (step_reg <= 6'h36) begin
            pin_next[2] = !step_reg[0];
            pin_next[3] = frame[5'(5'd26 - k)];
          end else if (step_reg != `DHP_I2C_LAST) begin
            pin_next[2] = step_reg != 6'h37;
            pin_next[3] = 1'b0;
          end
        end
        // scl driven push-pull, sda open drain on bit1 only
        oe_next = {6'h3f, pin_next[3], 1'b0};
        pin_next[3] = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      act_reg  <= 1'b0;
      step_reg <= 6'h00;
      div_reg  <= 7'h00;
      rd_reg   <= 1'b0;
      dc_reg   <= 1'b0;
      dat_reg  <= 8'h00;
      rv_reg   <= 1'b0;
      rdd_reg  <= 8'h00;
      pin_reg  <= 15'h47fc;
      oe_reg   <= 8'hff;
      mode_reg <= `DHP_MODE_SERIAL;
      rstp_reg <= 1'b1;
    end else begin
      act_reg  <= act_next;
      step_reg <= step_next;
      div_reg  <= div_next;
      rd_reg   <= rd_next;
      dc_reg   <= dc_next;
      dat_reg  <= dat_next;
      rv_reg   <= rv_next;
      rdd_reg  <= rdd_next;
      pin_reg  <= pin_next;
      oe_reg   <= oe_next;
      rstp_reg <= chip_reset_req_i;
      // straps follow mode_i only while reset is requested; the delayed copy
      // would still move them on the edge that lets the device run
      if (chip_reset_req_i) begin
        mode_reg <= mode_i;
      end
    end
  end

  assign pins.iface_strap_a = mode_reg[1];
  assign pins.iface_strap_b = mode_reg[0];
  assign pins.cs_n          = pin_reg[14];
  assign pins.dc            = pin_reg[13];
  assign pins.rw_wr_n       = pin_reg[12];
  assign pins.en_rd_n       = pin_reg[11];
  assign pins.chip_reset_n  = pin_reg[10] && !rstp_reg;
  assign pins.host_bus_o    = pin_reg[9:2];
  assign pins.host_bus_oe_n = oe_reg;
  assign ready_o            = !act_reg;
  assign rd_valid_o         = rv_reg;
  assign rd_data_o          = rdd_reg;
endmodule // dhp_host

// File: dv/dhp_assertions.sv
`include "dhp_defines.svh"
module dhp_assertions (
  input wire logic       clk_sys_i,
  input wire logic       reset_i,
  input wire logic       iface_strap_a,
  input wire logic       iface_strap_b,
  input wire logic       chip_reset_n,
  input wire logic       cs_n,
  input wire logic       rw_wr_n,
  input wire logic       en_rd_n,
  input wire logic [7:0] host_bus_oe_n,
  input wire logic [7:0] dev_bus_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] strap;
  assign strap = {iface_strap_a, iface_strap_b};

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  rst_release_a: assert property ($fell(reset_i) |-> cs_n && !chip_reset_n &&
    (dev_bus_oe_n == 8'hff) && (host_bus_oe_n == 8'hff)) else $error("pins not idle after reset");
  dev_idle_a: assert property ((strap != `DHP_MODE_I2C) && cs_n && $past(cs_n) &&
    $past(cs_n, 2) && $past(cs_n, 3) && $past(cs_n, 4) |-> dev_bus_oe_n == 8'hff)
    else $error("device drives bus while deselected");
  serial_strobe_a: assert property ((strap == `DHP_MODE_SERIAL) && chip_reset_n &&
    $past(chip_reset_n) |-> !rw_wr_n && !en_rd_n) else $error("strobes not low in serial mode");
  strap_fixed_a: assert property (!$stable(strap) |-> ##[0:2] !chip_reset_n)
    else $error("straps changed outside chip reset");
  en_hold_a: assert property ($rose(en_rd_n) && (strap == `DHP_MODE_PAR_EN) && chip_reset_n
    |-> (en_rd_n && !cs_n && $stable(rw_wr_n))[*8]) else $error("enable strobe badly framed");
  en_read_a: assert property ($rose(en_rd_n) && rw_wr_n && !cs_n && chip_reset_n &&
    (strap == `DHP_MODE_PAR_EN) |-> ##[1:5] dev_bus_oe_n == 8'h00)
    else $error("enable read not driven");
  sep_strobe_a: assert property ((strap == `DHP_MODE_PAR_SEP) && chip_reset_n &&
    ($fell(rw_wr_n) || $fell(en_rd_n)) |-> !cs_n) else $error("strobe without select");
  sep_read_a: assert property ($fell(en_rd_n) && !cs_n && chip_reset_n &&
    (strap == `DHP_MODE_PAR_SEP) |-> ##[1:5] dev_bus_oe_n == 8'h00)
    else $error("strobe read not driven");
  ser_pins_a: assert property ((strap == `DHP_MODE_SERIAL) && !cs_n && chip_reset_n
    |-> host_bus_oe_n[1:0] == 2'b00) else $error("serial clock or data not driven");
  i2c_pins_a: assert property ((strap == `DHP_MODE_I2C) |-> dev_bus_oe_n[7:3] == 5'h1f &&
    dev_bus_oe_n[1:0] == 2'b11) else $error("device drives a non sda bit in i2c");
  no_clash_a: assert property (strap[0] |-> (~host_bus_oe_n & ~dev_bus_oe_n) == 8'h00)
    else $error("both ends drive the bus");
endmodule // dhp_assertions

// File: dv/tb.sv
`include "dhp_defines.svh"
module tb
  import dhp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys_i, reset_i, chip_reset_req_i, slave_addr_low_bit_i;
  logic       req_i, req_read_i, req_dc_i;
  logic [1:0] mode_i;
  logic [7:0] req_data_i, rd_data_i;
  logic       ready_o, rd_valid_o, wr_stb_o, wr_is_data_o, rd_stb_o, init_active_o;
  logic       display_on_o, seg_remap_o, com_scan_rev_o, dc_seen;
  logic [7:0] rd_data_o, wr_data_o, col_addr_o, contrast_o, wr_seen, exp_col;
  logic [5:0] start_line_o;
  logic [1:0] modes [4];
  int         errors, num_checks, cycles, wr_cnt, rdv_cnt, rds_cnt;

  dhp_if u_dhp_if ();
  dhp_host u_dhp_host (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .pins(u_dhp_if),
    .mode_i(mode_i), .chip_reset_req_i(chip_reset_req_i),
    .slave_addr_low_bit_i(slave_addr_low_bit_i), .req_i(req_i), .req_read_i(req_read_i),
    .req_dc_i(req_dc_i), .req_data_i(req_data_i), .ready_o(ready_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o));
  dhp_device u_dhp_device (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .pins(u_dhp_if),
    .rd_data_i(rd_data_i), .wr_stb_o(wr_stb_o), .wr_data_o(wr_data_o),
    .wr_is_data_o(wr_is_data_o), .rd_stb_o(rd_stb_o), .init_active_o(init_active_o),
    .display_on_o(display_on_o), .start_line_o(start_line_o), .col_addr_o(col_addr_o),
    .seg_remap_o(seg_remap_o), .com_scan_rev_o(com_scan_rev_o), .contrast_o(contrast_o));
  dhp_assertions u_dhp_assertions (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .iface_strap_a(u_dhp_if.iface_strap_a), .iface_strap_b(u_dhp_if.iface_strap_b),
    .chip_reset_n(u_dhp_if.chip_reset_n), .cs_n(u_dhp_if.cs_n),
    .rw_wr_n(u_dhp_if.rw_wr_n), .en_rd_n(u_dhp_if.en_rd_n),
    .host_bus_oe_n(u_dhp_if.host_bus_oe_n), .dev_bus_oe_n(u_dhp_if.dev_bus_oe_n));

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic results();
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // pulses are counted here so a short strobe is never missed between checks
  always @(posedge clk_sys_i) begin
    cycles++;
    if (wr_stb_o === 1'b1) begin
      wr_cnt++;
      wr_seen = wr_data_o;
      dc_seen = wr_is_data_o;
    end
    if (rd_valid_o === 1'b1)
      rdv_cnt++;
    if (rd_stb_o === 1'b1)
      rds_cnt++;
    // i2c bytes take ~3800 cycles, the whole run well under this
    if (cycles == 40000) begin
      errors++;
      results();
    end
  end

  task automatic xfer(input logic rd, input logic dc, input logic [7:0] d);
    int n;
    @(posedge clk_sys_i);
    req_i <= 1'b1;
    req_read_i <= rd;
    req_dc_i <= dc;
    req_data_i <= d;
    @(posedge clk_sys_i);
    req_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (ready_o !== 1'b1 && n < 5000);
    // device pipe lags the pins by a few cycles
    repeat (6) @(posedge clk_sys_i);
  endtask

  task automatic chip_init(input logic [1:0] m);
    @(posedge clk_sys_i);
    mode_i <= m;
    chip_reset_req_i <= 1'b1;
    slave_addr_low_bit_i <= 1'($urandom);
    repeat (8) @(posedge clk_sys_i);
    check("init_active", 8'h01, {7'h0, init_active_o});
    check("contrast", `DHP_CONTRAST_RST, contrast_o);
    check("column", `DHP_COL_RST, col_addr_o);
    check("start_line", {2'h0, `DHP_START_RST}, {2'h0, start_line_o});
    check("mapping", 8'h00, {5'h0, display_on_o, seg_remap_o, com_scan_rev_o});
    chip_reset_req_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    check("init_done", 8'h00, {7'h0, init_active_o});
    exp_col = 8'h00;
  endtask

  task automatic do_write(input logic dc, input logic [7:0] d);
    int c0;
    int c1;
    c0 = wr_cnt;
    c1 = rds_cnt;
    xfer(1'b0, dc, d);
    check("write_count", 8'h01, 8'(wr_cnt - c0));
    check("write_no_read", 8'h00, 8'(rds_cnt - c1));
    check("write_data", d, wr_seen);
    check("write_kind", {7'h0, dc}, {7'h0, dc_seen});
    exp_col = exp_col + {7'h0, dc};
    check("column", exp_col, col_addr_o);
  endtask

  task automatic do_read(input logic dc);
    int c0;
    int c1;
    int w0;
    logic [7:0] v;
    v = 8'($urandom);
    c0 = rdv_cnt;
    c1 = rds_cnt;
    w0 = wr_cnt;
    @(posedge clk_sys_i);
    rd_data_i <= v;
    xfer(1'b1, dc, 8'h00);
    check("read_valid", 8'h01, 8'(rdv_cnt - c0));
    check("read_strobe", 8'h01, 8'(rds_cnt - c1));
    check("read_no_write", 8'h00, 8'(wr_cnt - w0));
    check("read_data", v, rd_data_o);
  endtask

  initial begin
    reset_i = 1'b1;
    mode_i = `DHP_MODE_PAR_EN;
    chip_reset_req_i = 1'b0;
    slave_addr_low_bit_i = 1'b0;
    req_i = 1'b0;
    req_read_i = 1'b0;
    req_dc_i = 1'b0;
    req_data_i = 8'h00;
    rd_data_i = 8'h00;
    modes = '{`DHP_MODE_PAR_EN, `DHP_MODE_PAR_SEP, `DHP_MODE_SERIAL, `DHP_MODE_I2C};
    void'($urandom(32'h5c644e12));
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    foreach (modes[k]) begin
      chip_init(modes[k]);
      do_write(1'b0, 8'h00);
      do_write(1'b1, 8'hff);
      do_write(1'b1, 8'h81);
      if (modes[k] != `DHP_MODE_I2C) begin
        for (int i = 0; i < 5; i++)
          do_write(1'($urandom), 8'($urandom));
      end
      if (modes[k][0]) begin
        for (int i = 0; i < 3; i++)
          do_read(1'($urandom));
      end
    end
    results();
  end
endmodule // tb
